/* File: uart_shadow_data_port.sv */
// uart shadow data port: aliased data window, fifos, serializer, apb slave
// Notes on behaviour
// - sixteen aliased words all reach the same receive and transmit data path
// - alias read gives received character in low byte, serial or infrared input
// - read data is meaningful only while the data ready flag is set
// - fifos off: new character overwrites unread one and flags overrun
// - fifos on: alias read returns and pops the receive fifo head
// - receive fifo full: keep contents, drop new character, flag overrun
// - alias write queues low byte for serial or active-low infrared output
// - fifos off: write clears empty flag; more writes overwrite pending char
// - fifos on: up to fifo depth writes, default sixteen, are accepted
// - write to a full transmit fifo is dropped, contents unchanged
`timescale 1ns/10ps
`include "uart_shadow_cfg.svh"
module uart_shadow_data_port
  import uart_shadow_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CLKS_PER_BIT = `CLKS_PER_BIT_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sin,
  input wire logic sir_in,
  output logic sout,
  output logic sir_out_n,
  output logic irq
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(CLKS_PER_BIT) + 1;
  localparam logic [PW:0] CAP_FIFO = (PW + 1)'(DEPTH);
  localparam logic [PW:0] CAP_ONE = (PW + 1)'(1);
  localparam logic [CW-1:0] DIV_FULL = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] DIV_HALF = CW'(CLKS_PER_BIT / 2);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] rxm;
    logic [PW-1:0] rx_rd;
    logic [PW-1:0] rx_wr;
    logic [PW:0] rx_cnt;
    logic [DEPTH-1:0][7:0] txm;
    logic [PW-1:0] tx_rd;
    logic [PW-1:0] tx_wr;
    logic [PW:0] tx_cnt;
    ser_state_t rs;
    logic [CW-1:0] rdiv;
    logic [2:0] rbit;
    logic [7:0] rsh;
    ser_state_t ts;
    logic [CW-1:0] tdiv;
    logic [2:0] tbit;
    logic [7:0] tsh;
    logic fifo_en;
    logic ir_mode;
    logic oe;
    logic [2:0] ist;
    logic [2:0] imask;
    logic rd_ok;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sout;
    logic sir_out_n;
    logic irq;
    logic [1:0] sin_s;
    logic [1:0] sir_s;
  } st_t;

  st_t s;
  st_t n;
  logic setup;
  logic acc;
  logic alias_hit;
  logic mapped;
  logic [31:0] aoff;
  logic rx_line;
  logic rx_done;
  logic rx_pop;
  logic tx_pop;
  logic tx_wr;
  logic [PW:0] cap;
  logic txb;

  // =====================================
  // next state
  always_comb begin
    n = s;
    setup = psel & ~penable;
    acc = psel & penable & s.pready;
    aoff = paddr - `ALIAS_BASE;
    alias_hit = (aoff < `ALIAS_SPAN) && (paddr[1:0] == 2'b00);
    mapped = alias_hit || paddr == `LINE_STATUS_OFS || paddr == `FIFO_CONTROL_OFS ||
             paddr == `MODE_OFS || paddr == `INT_STATUS_OFS || paddr == `INT_MASK_OFS;
    cap = s.fifo_en ? CAP_FIFO : CAP_ONE;
    rx_done = 1'b0;
    rx_pop = 1'b0;
    tx_pop = 1'b0;
    tx_wr = 1'b0;
    txb = 1'b1;
    // two-flop synchronisers
    n.sin_s = {s.sin_s[0], sin};
    n.sir_s = {s.sir_s[0], sir_in};
    // infrared input pulses high for a zero bit
    rx_line = s.ir_mode ? ~s.sir_s[1] : s.sin_s[1];

    // =====================================
    // apb: answer one cycle after setup
    n.pready = setup;
    n.pslverr = setup & ~mapped;
    if (setup) begin
      n.prdata = 32'h0000_0000;
      n.rd_ok = 1'b0;
      if (!pwrite) begin
        if (alias_hit) begin
          n.rd_ok = (s.rx_cnt != '0);
          if (s.rx_cnt != '0) begin
            n.prdata = {24'h00_0000, s.rxm[s.rx_rd]};
          end
        end else begin
          case (paddr)
            `LINE_STATUS_OFS: begin
              n.prdata[`LS_RX_READY_BIT] = (s.rx_cnt != '0);
              n.prdata[`LS_OE_BIT] = s.oe;
              n.prdata[`LS_TX_EMPTY_BIT] = (s.tx_cnt == '0);
              n.prdata[`LS_TEMT_BIT] = (s.tx_cnt == '0) && (s.ts == SER_IDLE);
            end
            `FIFO_CONTROL_OFS: n.prdata[`FC_EN_BIT] = s.fifo_en;
            `MODE_OFS: n.prdata[`MODE_IR_BIT] = s.ir_mode;
            `INT_STATUS_OFS: n.prdata[2:0] = s.ist;
            `INT_MASK_OFS: n.prdata[2:0] = s.imask;
            default: n.prdata = 32'h0000_0000;
          endcase
        end
      end
    end

    // completion edge: side effects of reads and writes
    if (acc && !s.pslverr) begin
      if (pwrite) begin
        if (alias_hit) begin
          tx_wr = 1'b1;
        end else begin
          case (paddr)
            `FIFO_CONTROL_OFS: n.fifo_en = pwdata[`FC_EN_BIT];
            `MODE_OFS: n.ir_mode = pwdata[`MODE_IR_BIT];
            `INT_MASK_OFS: n.imask = pwdata[2:0];
            default: n.imask = s.imask;
          endcase
        end
      end else begin
        if (alias_hit && s.rd_ok) begin
          rx_pop = 1'b1;
        end
        // clear only what was reported, so a new event is kept
        if (paddr == `LINE_STATUS_OFS && s.prdata[`LS_OE_BIT]) begin
          n.oe = 1'b0;
        end
        if (paddr == `INT_STATUS_OFS) begin
          n.ist = s.ist & ~s.prdata[2:0];
        end
      end
    end

    // =====================================
    // receiver
    case (s.rs)
      SER_IDLE: begin
        if (!rx_line) begin
          n.rs = SER_START;
          n.rdiv = DIV_HALF;
        end
      end
      SER_START: begin
        if (s.rdiv == '0) begin
          n.rs = rx_line ? SER_IDLE : SER_DATA;
          n.rdiv = DIV_FULL;
          n.rbit = 3'h0;
        end else begin
          n.rdiv = s.rdiv - 1'b1;
        end
      end
      SER_DATA: begin
        if (s.rdiv == '0) begin
          n.rsh = {rx_line, s.rsh[7:1]};
          n.rdiv = DIV_FULL;
          n.rbit = s.rbit + 1'b1;
          if (s.rbit == 3'h7) begin
            n.rs = SER_STOP;
          end
        end else begin
          n.rdiv = s.rdiv - 1'b1;
        end
      end
      SER_STOP: begin
        if (s.rdiv == '0) begin
          n.rs = SER_IDLE;
          rx_done = 1'b1;
        end else begin
          n.rdiv = s.rdiv - 1'b1;
        end
      end
      default: n.rs = SER_IDLE;
    endcase

    // receive buffer / fifo
    if (rx_pop) begin
      n.rx_rd = s.rx_rd + 1'b1;
    end
    if (rx_done) begin
      n.ist[`IST_RX_BIT] = 1'b1;
      if (s.rx_cnt != cap || rx_pop) begin
        n.rxm[s.rx_wr] = s.rsh;
        n.rx_wr = s.rx_wr + 1'b1;
      end else begin
        n.oe = 1'b1;
        n.ist[`IST_OE_BIT] = 1'b1;
        if (!s.fifo_en) begin
          n.rxm[s.rx_rd] = s.rsh;
        end
      end
    end
    n.rx_cnt = s.rx_cnt + (PW + 1)'(rx_done && (s.rx_cnt != cap || rx_pop))
               - (PW + 1)'(rx_pop);

    // =====================================
    // transmitter
    case (s.ts)
      SER_IDLE: begin
        if (s.tx_cnt != '0) begin
          tx_pop = 1'b1;
          n.tsh = s.txm[s.tx_rd];
          n.ts = SER_START;
          n.tdiv = DIV_FULL;
        end
      end
      SER_START: begin
        if (s.tdiv == '0) begin
          n.ts = SER_DATA;
          n.tdiv = DIV_FULL;
          n.tbit = 3'h0;
        end else begin
          n.tdiv = s.tdiv - 1'b1;
        end
      end
      SER_DATA: begin
        if (s.tdiv == '0) begin
          n.tsh = {1'b1, s.tsh[7:1]};
          n.tdiv = DIV_FULL;
          n.tbit = s.tbit + 1'b1;
          if (s.tbit == 3'h7) begin
            n.ts = SER_STOP;
          end
        end else begin
          n.tdiv = s.tdiv - 1'b1;
        end
      end
      SER_STOP: begin
        if (s.tdiv == '0) begin
          n.ts = SER_IDLE;
        end else begin
          n.tdiv = s.tdiv - 1'b1;
        end
      end
      default: n.ts = SER_IDLE;
    endcase

    // transmit holding / fifo
    if (tx_pop) begin
      n.tx_rd = s.tx_rd + 1'b1;
    end
    if (tx_wr) begin
      if (s.tx_cnt != cap || tx_pop) begin
        n.txm[s.tx_wr] = pwdata[7:0];
        n.tx_wr = s.tx_wr + 1'b1;
      end else if (!s.fifo_en) begin
        n.txm[s.tx_rd] = pwdata[7:0];
      end
      // full fifo: write dropped
    end
    n.tx_cnt = s.tx_cnt + (PW + 1)'(tx_wr && (s.tx_cnt != cap || tx_pop))
               - (PW + 1)'(tx_pop);
    if (tx_pop && s.tx_cnt == CAP_ONE && !tx_wr) begin
      n.ist[`IST_TX_EMPTY_BIT] = 1'b1;
    end

    // fifo enable change flushes both queues
    if (n.fifo_en != s.fifo_en) begin
      n.rx_rd = '0;
      n.rx_wr = '0;
      n.rx_cnt = '0;
      n.tx_rd = '0;
      n.tx_wr = '0;
      n.tx_cnt = '0;
    end

    // line drive from next serializer state
    case (n.ts)
      SER_START: txb = 1'b0;
      SER_DATA: txb = n.tsh[0];
      default: txb = 1'b1;
    endcase
    n.sout = s.ir_mode ? 1'b1 : txb;
    n.sir_out_n = s.ir_mode ? txb : 1'b1;
    n.irq = |(n.ist & n.imask);
  end

  // =====================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.fifo_en <= `FIFO_EN_RST;
      s.ir_mode <= `IR_MODE_RST;
      s.imask <= `INT_MASK_RST;
      s.sout <= 1'b1;
      s.sir_out_n <= 1'b1;
      s.sin_s <= 2'b11;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign sout = s.sout;
  assign sir_out_n = s.sir_out_n;
  assign irq = s.irq;
endmodule : uart_shadow_data_port

/* File: uart_shadow_cfg.svh */
// addresses, field positions and reset values of the shadow data port
`ifndef UART_SHADOW_CFG_SVH
`define UART_SHADOW_CFG_SVH
// =====================================
// address map
`define ALIAS_BASE 32'h5000_1130
`define ALIAS_SPAN 32'h0000_0040
`define ALIAS_4_OFS 32'h5000_1140
`define ALIAS_5_OFS 32'h5000_1144
`define LINE_STATUS_OFS 32'h5000_1180
`define FIFO_CONTROL_OFS 32'h5000_1184
`define MODE_OFS 32'h5000_1188
`define INT_STATUS_OFS 32'h5000_118C
`define INT_MASK_OFS 32'h5000_1190
// =====================================
// field positions
`define LS_RX_READY_BIT 0
`define LS_OE_BIT 1
`define LS_TX_EMPTY_BIT 5
`define LS_TEMT_BIT 6
`define FC_EN_BIT 0
`define MODE_IR_BIT 0
`define IST_RX_BIT 0
`define IST_OE_BIT 1
`define IST_TX_EMPTY_BIT 2
// =====================================
// reset values and timing
`define FIFO_EN_RST 1'b0
`define IR_MODE_RST 1'b0
`define INT_MASK_RST 3'h0
`define CLKS_PER_BIT_DEF 16
`endif

/* File: uart_shadow_pkg.sv */
// types shared by the shadow data port
package uart_shadow_pkg;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b11,
    SER_STOP = 2'b10
  } ser_state_t;
endpackage : uart_shadow_pkg

/* File: uart_shadow_props.sv */
// assertions on the shadow data port pins
`timescale 1ns/10ps
`include "uart_shadow_cfg.svh"
module uart_shadow_props #(
  parameter int DEPTH = 16,
  parameter int CLKS_PER_BIT = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sout,
  input wire logic sir_out_n
);
  // ======
  // helpers
  logic setup;
  logic is_alias;
  logic [15:0] lo_cnt;
  assign setup = psel && !penable;
  assign is_alias = paddr >= `ALIAS_BASE && paddr < `ALIAS_BASE + `ALIAS_SPAN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt <= 16'h0;
    end else begin
      lo_cnt <= sout ? 16'h0 : lo_cnt + 16'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // checks
  ans_next_a: assert property (setup |=> pready)
    else $error("no answer after setup");
  ans_once_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  ans_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("answer without setup");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  misalign_err_a: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access accepted");
  alias_ok_a: assert property (setup && is_alias && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("alias access refused");
  alias_upper_a: assert property (pready && !pwrite && is_alias |-> prdata[31:8] == 24'h0)
    else $error("alias upper bits not zero");
  rdata_hold_a: assert property (!setup |=> $stable(prdata))
    else $error("read data moved without setup");
  line_excl_a: assert property (!sout |-> sir_out_n)
    else $error("both outputs active");
  start_len_a: assert property ($rose(sout) |-> lo_cnt != 0 && lo_cnt % CLKS_PER_BIT == 0)
    else $error("low run not whole bits");
  cover property (pslverr);
  cover property ($rose(sout));
  cover property (!sir_out_n);
  cover property (pready && !pwrite && is_alias && prdata[7:0] != 8'h0);
endmodule : uart_shadow_props
bind uart_shadow_data_port uart_shadow_props #(.DEPTH(DEPTH), .CLKS_PER_BIT(CLKS_PER_BIT)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sout(sout),
  .sir_out_n(sir_out_n));

/* File: uart_far_end.sv */
// remote serial end: sends frames on both inputs, collects frames from either output
`timescale 1ns/10ps
module uart_far_end #(
  parameter int CPB = 4
) (
  input wire logic pclk,
  output logic sin,
  output logic sir_in,
  input wire logic sout,
  input wire logic sir_out_n
);
  // ======
  // frames
  logic [7:0] got[$];
  logic [7:0] c;
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sin <= f[i];
      sir_in <= !f[i];
      repeat (CPB) @(posedge pclk);
    end
  endtask : send
  always begin
    @(negedge (sout & sir_out_n));
    repeat (CPB / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (CPB) @(posedge pclk);
      c[i] = sout & sir_out_n;
    end
    repeat (CPB) @(posedge pclk);
    got.push_back(c);
  end
endmodule : uart_far_end

/* File: tb.sv */
// self-checking bench for the shadow data port
`timescale 1ns/10ps
`include "uart_shadow_cfg.svh"
module tb;
  localparam int cpb = 4;
  localparam int depth = 4;
  localparam logic [31:0] ls_idle = (1 << `LS_TX_EMPTY_BIT) | (1 << `LS_TEMT_BIT);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sin, sir_in, sout, sir_out_n, irq;
  logic [33:0] notes[$];
  logic [33:0] nt;
  logic [7:0] c[8];
  int mismatches = 0;
  int n_checks = 0;
  always #10 pclk = ~pclk;
  uart_shadow_data_port #(.DEPTH(depth), .CLKS_PER_BIT(cpb)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sin(sin),
    .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));
  uart_far_end #(.CPB(cpb)) far (.pclk(pclk), .sin(sin), .sir_in(sir_in), .sout(sout),
    .sir_out_n(sir_out_n));
  // ======
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, d, input logic e, input logic [31:0] r);
    notes.push_back({!w, e, r});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [31:0] a, r);
    xfer(1'b0, a, 32'h0, 1'b0, r);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'($urandom), d}, 1'b0, 32'h0);
  endtask : wr
  task automatic wait_far(input int n);
    while (far.got.size() < n) @(posedge pclk);
  endtask : wait_far
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // ======
  // answer monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
      if (nt[33]) chk("prdata", nt[31:0], prdata);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    final_report();
  end
  // ======
  // tests
  initial begin
    void'($urandom(80));
    foreach (c[i]) c[i] = 8'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FIFO_CONTROL_OFS, 32'h0);
    rd(`INT_MASK_OFS, 32'h0);
    rd(`LINE_STATUS_OFS, ls_idle);
    xfer(1'b0, `INT_MASK_OFS + 32'h4, 32'h0, 1'b1, 32'h0);
    xfer(1'b1, `ALIAS_4_OFS + 32'h1, 32'h0, 1'b1, 32'h0);
    rd(`ALIAS_5_OFS, 32'h0);
    $display("test reset done");
    wr(`ALIAS_4_OFS, c[0]);
    wr(`ALIAS_5_OFS, c[1]);
    wr(`ALIAS_BASE + 32'h3C, c[2]);
    rd(`LINE_STATUS_OFS, 32'h0);
    wait_far(2);
    chk("tx0", {24'h0, c[0]}, {24'h0, far.got[0]});
    chk("tx1", {24'h0, c[2]}, {24'h0, far.got[1]});
    $display("test tx single done");
    chk("irq", 32'h0, {31'h0, irq});
    rd(`INT_STATUS_OFS, 32'h4);
    wr(`INT_MASK_OFS, 8'h1);
    far.send(c[3]);
    far.send(c[4]);
    repeat (8) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`LINE_STATUS_OFS, ls_idle | 32'h3);
    rd(`ALIAS_BASE + 32'hC, {24'h0, c[4]});
    rd(`LINE_STATUS_OFS, ls_idle);
    rd(`INT_STATUS_OFS, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test rx single done");
    wr(`FIFO_CONTROL_OFS, 8'h1);
    far.got.delete();
    for (int i = 0; i <= depth; i++) far.send(c[i]);
    repeat (8) @(posedge pclk);
    rd(`LINE_STATUS_OFS, ls_idle | 32'h3);
    for (int i = 0; i < depth; i++) rd(`ALIAS_BASE + 4 * i, {24'h0, c[i]});
    rd(`ALIAS_4_OFS, 32'h0);
    for (int i = 0; i < depth + 2; i++) wr(`ALIAS_BASE + 4 * i, c[i]);
    wait_far(depth + 1);
    for (int i = 0; i <= depth; i++) chk("txf", {24'h0, c[i]}, {24'h0, far.got[i]});
    $display("test fifo done");
    wr(`MODE_OFS, 8'h1);
    rd(`MODE_OFS, 32'h1);
    far.got.delete();
    far.send(c[5]);
    repeat (8) @(posedge pclk);
    rd(`ALIAS_BASE + 32'h8, {24'h0, c[5]});
    wr(`ALIAS_BASE + 32'h10, c[6]);
    wait_far(1);
    chk("txir", {24'h0, c[6]}, {24'h0, far.got[0]});
    $display("test infrared done");
    final_report();
  end
endmodule : tb
